// file: design/pbg_pkg.sv
// Constants, tables and carrier types shared by the peripheral bus gateway.
package pbg_pkg;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    localparam int PBG_REGION_LSB = 16;
    localparam logic [15:0] PBG_SER_BASE = 16'h8000;
    localparam logic [15:0] PBG_LCD_BASE = 16'hb010;
    localparam logic [15:0] PBG_PIN_BASE = 16'h9006;
    localparam int PBG_NUM_ENG = 8;
    localparam int PBG_NUM_UNITS = 10;
    localparam logic [3:0] PBG_UNIT_LCD = 4'h8;
    localparam logic [3:0] PBG_UNIT_PIN = 4'h9;
    localparam logic [15:0] PBG_OFS_PIN_DIR = 16'h0000;
    localparam logic [15:0] PBG_OFS_PIN_LVL = 16'h0004;
    localparam logic [1:0] PBG_SIZE_WORD = 2'h2;

    // ------------------------------------------------------------
    // Engine numbering, in address order
    // ------------------------------------------------------------
    localparam int PBG_ENG_USB = 0;
    localparam int PBG_ENG_UART1 = 1;
    localparam int PBG_ENG_GCLK = 2;
    localparam int PBG_ENG_IRUART = 3;
    localparam int PBG_ENG_FIR = 4;
    localparam int PBG_ENG_UART3 = 5;
    localparam int PBG_ENG_CODEC = 6;
    localparam int PBG_ENG_SSP = 7;

    // ------------------------------------------------------------
    // Interrupt pending bit positions
    // ------------------------------------------------------------
    localparam int PBG_IRQ_LCD = 12;
    localparam int PBG_IRQ_USB = 13;
    localparam int PBG_IRQ_SP1 = 15;
    localparam int PBG_IRQ_SP2 = 16;
    localparam int PBG_IRQ_SP3 = 17;
    localparam int PBG_IRQ_CODEC = 18;
    localparam int PBG_IRQ_SSP = 19;

    // ------------------------------------------------------------
    // Dedicated pins and their groups
    // ------------------------------------------------------------
    localparam int PBG_NUM_PINS = 24;
    localparam int PBG_NUM_GROUPS = 6;
    localparam int PBG_GRP_LCD = 0;
    localparam int PBG_GRP_SP0 = 1;
    localparam int PBG_PIN_LCD_LSB = 0;
    localparam int PBG_PIN_LCD_N = 12;
    localparam int PBG_PIN_SP0_LSB = 12;
    localparam int PBG_PIN_SP1_LSB = 14;
    localparam int PBG_PIN_SP2_LSB = 16;
    localparam int PBG_PIN_SP3_LSB = 18;
    localparam int PBG_PIN_SP_N = 2;
    localparam int PBG_PIN_SP4_LSB = 20;
    localparam int PBG_PIN_SP4_N = 4;

    // ------------------------------------------------------------
    // Register widths and DMA attributes
    // ------------------------------------------------------------
    localparam logic [31:0] PBG_MASK_8 = 32'h0000_00ff;
    localparam logic [31:0] PBG_MASK_16 = 32'h0000_ffff;
    localparam logic [31:0] PBG_MASK_32 = 32'hffff_ffff;
    localparam logic [4:0] PBG_BURST_NONE = 5'h00;
    localparam logic [4:0] PBG_BURST_4B = 5'h04;
    localparam logic [4:0] PBG_BURST_8B = 5'h08;
    localparam logic [4:0] PBG_BURST_4W = 5'h10;
    localparam logic [2:0] PBG_PORT_BYTE = 3'h1;
    localparam logic [2:0] PBG_PORT_HALF = 3'h2;
    localparam logic [2:0] PBG_PORT_WORD = 3'h4;

    typedef enum logic [2:0] {
        PBG_ST_IDLE = 3'b001,
        PBG_ST_WAIT = 3'b010,
        PBG_ST_RESP = 3'b100
    } pbg_state_type;

    typedef struct packed {
        logic        write;
        logic [1:0]  size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } pbg_sys_req_type;

    typedef struct packed {
        logic [4:0] burst_bytes;
        logic [2:0] port_bytes;
    } pbg_dma_attr_type;

    // Widest coherent transfer of each unit, right justified in the word.
    function automatic logic [31:0] pbg_unit_mask(input logic [3:0] unit);
        case (unit)
            4'h6, 4'h7: pbg_unit_mask = PBG_MASK_16;
            PBG_UNIT_LCD, PBG_UNIT_PIN: pbg_unit_mask = PBG_MASK_32;
            default: pbg_unit_mask = PBG_MASK_8;
        endcase
    endfunction

    function automatic pbg_dma_attr_type pbg_dma_attr(input logic [3:0] unit);
        case (unit)
            4'h0, 4'h4: pbg_dma_attr = '{PBG_BURST_8B, PBG_PORT_BYTE};
            4'h1, 4'h3, 4'h5: pbg_dma_attr = '{PBG_BURST_4B, PBG_PORT_BYTE};
            4'h6, 4'h7: pbg_dma_attr = '{PBG_BURST_8B, PBG_PORT_HALF};
            PBG_UNIT_LCD: pbg_dma_attr = '{PBG_BURST_4W, PBG_PORT_WORD};
            default: pbg_dma_attr = '{PBG_BURST_NONE, PBG_PORT_BYTE};
        endcase
    endfunction

endpackage

// file: design/pbg_pin_ctl.sv
// Dedicated pin multiplexer with input synchronisers for the gateway's pin controller.
`timescale 1ns/10ps
module pbg_pin_ctl #(
    parameter int WIDTH = 24
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic [WIDTH-1:0] i_own_mask,
    input wire logic [WIDTH-1:0] i_per_out,
    input wire logic [WIDTH-1:0] i_per_oe,
    input wire logic [WIDTH-1:0] i_dir,
    input wire logic [WIDTH-1:0] i_lvl,
    input wire logic [WIDTH-1:0] i_pin_in,
    output logic [WIDTH-1:0] o_pin_out,
    output logic [WIDTH-1:0] o_pin_oe,
    output logic [WIDTH-1:0] o_sampled
);

    logic [WIDTH-1:0] sync1_r;
    logic [WIDTH-1:0] sync2_r;
    logic [WIDTH-1:0] sync3_r;
    logic [WIDTH-1:0] sampled_nxt;
    wire [WIDTH-1:0] agree = ~(sync2_r ^ sync3_r);
    wire [WIDTH-1:0] out_nxt = (i_own_mask & i_per_out) | (~i_own_mask & i_lvl);
    wire [WIDTH-1:0] oe_nxt = (i_own_mask & i_per_oe) | (~i_own_mask & i_dir);

    // A pin change is accepted once the second and third stages agree.
    assign sampled_nxt = (agree & sync3_r) | (~agree & o_sampled);

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
            o_sampled <= '0;
            o_pin_out <= '0;
            o_pin_oe <= '0;
        end else begin
            sync1_r <= i_pin_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            o_sampled <= sampled_nxt;
            o_pin_out <= out_nxt;
            o_pin_oe <= oe_nxt;
        end
    end

endmodule // pbg_pin_ctl

// file: design/pbg_gateway.sv
// Peripheral bus gateway: system bus decode, peripheral strobes, DMA, interrupts and pins.
//
// How it works
// (R1) Only full word accesses pass; byte or half-word requests end in an error.
// (R2) Each unit's register is 8, 16 or 32 bits wide, right justified.
// (R3) DMA attributes: display 4 words, USB/fast IR/16-bit 8 bytes, async 4 bytes.
// (R4) Every serial engine and the pin controller own one 64 Kbyte region.
// (R5) Serial engines sit at consecutive regions; display and pin controller own bases.
// (R6) Processor reads and writes get strobes and decode for every peripheral unit; the pin controller is decoded inside the gateway and gets no strobe.
// (R7) The pin controller never raises a DMA request.
// (R8) Unit interrupts land on pending bits 12, 13, 15, 16, 17, 18, 19.
// (R9) The general clock engine in serial port 1 raises no interrupt.
// (R10) Both blocks of serial ports 1 and 4 work at once, one via borrowed pins.
// (R11) Each engine has its own select and request; the IR UART and fast IR share pending bit 16, and the general clock engine has no interrupt.
// (R12) A disabled peripheral's pins fall to the pin controller's direction and level.
// (R13) The level register reads sampled inputs and writes drive output levels.
// (R14) The direction register picks input or output for each dedicated pin.
// (R15) Unused peripheral pins become plain I/O, except the two USB pins.
// (R16) The pin controller handles 24 pins: 12 display, 4 port 4, 2 each others.
// (R17) Unused upper bits read as zero and are dropped on writes.
`timescale 1ns/10ps
module pbg_gateway
    import pbg_pkg::*;
#(
    parameter int NUM_PINS = PBG_NUM_PINS
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    // System bus request and answer.
    input wire logic i_sys_valid,
    input wire pbg_sys_req_type i_sys_req,
    output logic o_sys_ready,
    output logic o_sys_ack,
    output logic o_sys_err,
    output logic [31:0] o_sys_rdata,
    // Peripheral bus towards the serial engines and the display unit.
    output logic [PBG_NUM_UNITS-2:0] o_pbus_sel,
    output logic o_pbus_write,
    output logic [15:0] o_pbus_addr,
    output logic [31:0] o_pbus_wdata,
    input wire logic [31:0] i_pbus_rdata,
    input wire logic i_pbus_ready,
    // DMA requests and per-unit transfer attributes.
    input wire logic [PBG_NUM_ENG-1:0] i_eng_dma_req,
    output logic [PBG_NUM_ENG-1:0] o_dma_req,
    input wire logic [3:0] i_dma_unit,
    output pbg_dma_attr_type o_dma_attr,
    // Interrupt lines from the units and the pending vector they form.
    input wire logic [PBG_NUM_ENG-1:0] i_eng_irq,
    input wire logic i_lcd_irq,
    output logic [31:0] o_irq_pend,
    // Dedicated pins.
    input wire logic [PBG_NUM_GROUPS-1:0] i_unit_en,
    input wire logic [NUM_PINS-1:0] i_per_pin_out,
    input wire logic [NUM_PINS-1:0] i_per_pin_oe,
    output logic [NUM_PINS-1:0] o_per_pin_in,
    input wire logic [NUM_PINS-1:0] i_pin_in,
    output logic [NUM_PINS-1:0] o_pin_out,
    output logic [NUM_PINS-1:0] o_pin_oe
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (NUM_PINS != PBG_NUM_PINS) begin : g_bad_pins
        $error("pbg_gateway: pin count must match the pin controller map");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    pbg_state_type state_r;
    pbg_state_type state_nxt;
    logic [3:0] unit_r;
    logic [NUM_PINS-1:0] pin_dir_r;
    logic [NUM_PINS-1:0] pin_lvl_r;
    logic [NUM_PINS-1:0] pin_sampled;
    logic [NUM_PINS-1:0] own_mask;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire [15:0] region = i_sys_req.addr[31:PBG_REGION_LSB];
    wire [15:0] offset = i_sys_req.addr[PBG_REGION_LSB-1:0];
    wire [15:0] ser_delta = region - PBG_SER_BASE;
    wire hit_ser = (region[15:3] == PBG_SER_BASE[15:3]); // R4 R5
    wire hit_lcd = (region == PBG_LCD_BASE); // R5
    wire hit_pin = (region == PBG_PIN_BASE); // R4 R5
    wire is_word = (i_sys_req.size == PBG_SIZE_WORD) && (i_sys_req.addr[1:0] == 2'h0); // R1
    wire hit_any = hit_ser | hit_lcd | hit_pin;
    wire [3:0] unit_dec = hit_lcd ? PBG_UNIT_LCD :
                          hit_pin ? PBG_UNIT_PIN : {1'b0, ser_delta[2:0]}; // R5
    wire [31:0] unit_mask = pbg_unit_mask(unit_dec); // R2
    wire [31:0] held_mask = pbg_unit_mask(unit_r); // R2
    wire take = i_sys_valid && (state_r == PBG_ST_IDLE);
    wire bad_req = !is_word || !hit_any; // R1
    wire to_pbus = take && !bad_req && !hit_pin; // R6

    // Pin controller registers in its own region.
    wire pin_dir_hit = hit_pin && (offset == PBG_OFS_PIN_DIR);
    wire pin_lvl_hit = hit_pin && (offset == PBG_OFS_PIN_LVL);
    wire pin_wr = take && is_word && i_sys_req.write;
    wire [NUM_PINS-1:0] pin_wdata = i_sys_req.wdata[NUM_PINS-1:0]; // R17
    wire [31:0] pin_rdata = pin_dir_hit ? {{(32-NUM_PINS){1'b0}}, pin_dir_r} :
                            pin_lvl_hit ? {{(32-NUM_PINS){1'b0}}, pin_sampled} : 32'h0000_0000; // R13

    // ------------------------------------------------------------
    // Access sequencer
    // ------------------------------------------------------------
    assign o_sys_ready = (state_r == PBG_ST_IDLE);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            PBG_ST_IDLE: begin
                if (to_pbus) begin
                    state_nxt = PBG_ST_WAIT;
                end else if (take) begin
                    state_nxt = PBG_ST_RESP;
                end
            end
            PBG_ST_WAIT: begin
                if (i_pbus_ready) begin
                    state_nxt = PBG_ST_RESP;
                end
            end
            PBG_ST_RESP: begin
                state_nxt = PBG_ST_IDLE;
            end
            default: begin
                state_nxt = PBG_ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state_r <= PBG_ST_IDLE;
            unit_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            if (take) begin
                unit_r <= unit_dec;
            end
        end
    end

    // ------------------------------------------------------------
    // Peripheral bus strobes
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pbus_sel <= '0;
            o_pbus_write <= 1'b0;
            o_pbus_addr <= 16'h0000;
            o_pbus_wdata <= 32'h0000_0000;
        end else if (to_pbus) begin
            o_pbus_sel <= (PBG_NUM_UNITS-1)'(1) << unit_dec; // R6 R11
            o_pbus_write <= i_sys_req.write;
            o_pbus_addr <= offset;
            o_pbus_wdata <= i_sys_req.wdata & unit_mask; // R2 R17
        end else if ((state_r == PBG_ST_WAIT) && i_pbus_ready) begin
            o_pbus_sel <= '0;
            o_pbus_write <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // System bus answer
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_sys_ack <= 1'b0;
            o_sys_err <= 1'b0;
            o_sys_rdata <= 32'h0000_0000;
        end else begin
            o_sys_ack <= 1'b0;
            if (take && !to_pbus) begin
                o_sys_ack <= 1'b1;
                o_sys_err <= bad_req; // R1
                o_sys_rdata <= (bad_req || i_sys_req.write) ? 32'h0000_0000 : pin_rdata;
            end else if ((state_r == PBG_ST_WAIT) && i_pbus_ready) begin
                o_sys_ack <= 1'b1;
                o_sys_err <= 1'b0;
                o_sys_rdata <= o_pbus_write ? 32'h0000_0000 : (i_pbus_rdata & held_mask); // R2 R17
            end
        end
    end

    // ------------------------------------------------------------
    // Pin controller registers
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            pin_dir_r <= '0;
            pin_lvl_r <= '0;
        end else begin
            if (pin_wr && pin_dir_hit) begin
                pin_dir_r <= pin_wdata; // R14
            end
            if (pin_wr && pin_lvl_hit) begin
                pin_lvl_r <= pin_wdata; // R13
            end
        end
    end

    // ------------------------------------------------------------
    // Pin ownership
    // ------------------------------------------------------------
    assign own_mask = {
        {PBG_PIN_SP4_N{i_unit_en[5]}},
        {PBG_PIN_SP_N{i_unit_en[4]}},
        {PBG_PIN_SP_N{i_unit_en[3]}},
        {PBG_PIN_SP_N{i_unit_en[2]}},
        {PBG_PIN_SP_N{1'b1}},
        {PBG_PIN_LCD_N{i_unit_en[PBG_GRP_LCD]}}
    }; // R12 R15 R16

    pbg_pin_ctl #(
        .WIDTH(NUM_PINS)
    ) u_pins (
        .i_core_clk(i_core_clk),
        .i_rst(i_rst),
        .i_own_mask(own_mask),
        .i_per_out(i_per_pin_out),
        .i_per_oe(i_per_pin_oe),
        .i_dir(pin_dir_r),
        .i_lvl(pin_lvl_r),
        .i_pin_in(i_pin_in),
        .o_pin_out(o_pin_out),
        .o_pin_oe(o_pin_oe),
        .o_sampled(pin_sampled)
    ); // R12 R13 R14

    assign o_per_pin_in = pin_sampled;

    // ------------------------------------------------------------
    // DMA requests and attributes
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_dma_req <= '0;
            o_dma_attr <= '{PBG_BURST_NONE, PBG_PORT_BYTE};
        end else begin
            o_dma_req <= i_eng_dma_req; // R7 R11
            o_dma_attr <= pbg_dma_attr(i_dma_unit); // R3 R7
        end
    end

    // ------------------------------------------------------------
    // Interrupt routing
    // ------------------------------------------------------------
    logic [31:0] irq_nxt;

    always_comb begin
        irq_nxt = 32'h0000_0000;
        irq_nxt[PBG_IRQ_LCD] = i_lcd_irq; // R8
        irq_nxt[PBG_IRQ_USB] = i_eng_irq[PBG_ENG_USB]; // R8
        irq_nxt[PBG_IRQ_SP1] = i_eng_irq[PBG_ENG_UART1]; // R8 R9
        irq_nxt[PBG_IRQ_SP2] = i_eng_irq[PBG_ENG_IRUART] | i_eng_irq[PBG_ENG_FIR]; // R8
        irq_nxt[PBG_IRQ_SP3] = i_eng_irq[PBG_ENG_UART3]; // R8
        irq_nxt[PBG_IRQ_CODEC] = i_eng_irq[PBG_ENG_CODEC]; // R8 R10
        irq_nxt[PBG_IRQ_SSP] = i_eng_irq[PBG_ENG_SSP]; // R8 R10
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_irq_pend <= 32'h0000_0000;
        end else begin
            o_irq_pend <= irq_nxt;
        end
    end

endmodule // pbg_gateway

// file: sim/pbg_gateway_sva.sv
// Concurrent checks on the ports of the peripheral bus gateway.
`timescale 1ns/10ps
module pbg_gateway_sva
    import pbg_pkg::*;
#(
    parameter int NUM_PINS = PBG_NUM_PINS
) (
    input wire logic i_core_clk,
    input wire logic i_rst,
    input wire logic i_sys_valid,
    input wire pbg_sys_req_type i_sys_req,
    input wire logic o_sys_ready,
    input wire logic o_sys_ack,
    input wire logic o_sys_err,
    input wire logic [31:0] o_sys_rdata,
    input wire logic [PBG_NUM_UNITS-2:0] o_pbus_sel,
    input wire logic o_pbus_write,
    input wire logic [15:0] o_pbus_addr,
    input wire logic [31:0] o_pbus_wdata,
    input wire logic i_pbus_ready,
    input wire logic [3:0] i_dma_unit,
    input wire pbg_dma_attr_type o_dma_attr,
    input wire logic [PBG_NUM_ENG-1:0] i_eng_irq,
    input wire logic i_lcd_irq,
    input wire logic [31:0] o_irq_pend,
    input wire logic [NUM_PINS-1:0] i_per_pin_oe,
    input wire logic [NUM_PINS-1:0] o_pin_oe
);
    logic [1:0] live_r;
    wire take = i_sys_valid && o_sys_ready;
    wire bad = i_sys_req.size != PBG_SIZE_WORD;
    wire ser = i_sys_req.addr[31:19] == 13'h1000 && !bad && i_sys_req.addr[1:0] == 2'h0;
    wire [31:0] irq_exp = {12'h0, i_eng_irq[7:5], i_eng_irq[4] | i_eng_irq[3], i_eng_irq[1],
        1'b0, i_eng_irq[0], i_lcd_irq, 12'h0};
    // Set two edges after reset, once outputs track inputs.
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) live_r <= 2'h0;
        else live_r <= {live_r[0], 1'b1};
    end
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_rst);
    property p_err_size;
        take && bad |=> o_sys_ack && o_sys_err && o_pbus_sel == '0;
    endproperty
    a_err_size: assert property (p_err_size) else $error("not refused");
    property p_take_busy;
        take |=> !o_sys_ready;
    endproperty
    a_take_busy: assert property (p_take_busy) else $error("ready after take");
    property p_ack_one;
        o_sys_ack |=> !o_sys_ack && o_sys_ready;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack too long");
    property p_ser_sel;
        take && ser |=> o_pbus_sel == (9'h001 << $past(i_sys_req.addr[18:16]))
            && o_pbus_addr == $past(i_sys_req.addr[15:0]);
    endproperty
    a_ser_sel: assert property (p_ser_sel) else $error("bad select");
    property p_hold;
        |o_pbus_sel && !i_pbus_ready |=>
            $stable({o_pbus_sel, o_pbus_addr, o_pbus_wdata, o_pbus_write});
    endproperty
    a_hold: assert property (p_hold) else $error("not held");
    property p_done;
        |o_pbus_sel && i_pbus_ready |=> o_sys_ack && o_pbus_sel == '0;
    endproperty
    a_done: assert property (p_done) else $error("not ended");
    property p_rd_mask;
        |o_pbus_sel[5:0] && i_pbus_ready && !o_pbus_write |=> o_sys_rdata[31:8] == '0;
    endproperty
    a_rd_mask: assert property (p_rd_mask) else $error("read upper bits");
    property p_wd_mask;
        |o_pbus_sel[7:6] |-> o_pbus_wdata[31:16] == '0;
    endproperty
    a_wd_mask: assert property (p_wd_mask) else $error("write upper bits");
    property p_pin_attr;
        i_dma_unit == PBG_UNIT_PIN |=> o_dma_attr.burst_bytes == PBG_BURST_NONE;
    endproperty
    a_pin_attr: assert property (p_pin_attr) else $error("pin burst");
    property p_irq_map;
        live_r[1] |-> o_irq_pend == $past(irq_exp);
    endproperty
    a_irq_map: assert property (p_irq_map) else $error("bad pending");
    property p_usb_pins;
        live_r[1] |-> o_pin_oe[13:12] == $past(i_per_pin_oe[13:12]);
    endproperty
    a_usb_pins: assert property (p_usb_pins) else $error("usb oe");
    c_ser: cover property (take && ser);
    c_bad: cover property (take && bad);
    c_pin: cover property (take && i_sys_req.addr[31:16] == PBG_PIN_BASE);
endmodule // pbg_gateway_sva

// file: sim/pbg_pbus_model.sv
// Behavioural peripheral units answering the gateway's peripheral bus.
`timescale 1ns/10ps
module pbg_pbus_model (
    input wire logic i_core_clk,
    input wire logic [8:0] i_sel,
    input wire logic i_write,
    input wire logic [31:0] i_wdata,
    input wire logic [2:0] i_delay,
    output logic o_ready,
    output logic [31:0] o_rdata
);
    logic [31:0] mem_r [0:8];
    logic [2:0] cnt_r = 3'h0;
    logic [31:0] junk_r = 32'h5a3c_96e1;
    logic [3:0] unit;
    initial o_ready = 1'b0;
    always_comb begin
        unit = 4'h0;
        for (int i = 0; i < 9; i++) if (i_sel[i]) unit = 4'(i);
    end
    wire [31:0] keep = unit == 4'h8 ? 32'hffff_ffff : unit > 4'h5 ? 32'h0000_ffff
        : 32'h0000_00ff;
    assign o_rdata = |i_sel ? (mem_r[unit] & keep) | (junk_r & ~keep) : junk_r;
    always @(posedge i_core_clk) begin
        junk_r <= junk_r + 32'h9e37_79b9;
        o_ready <= 1'b0;
        if (|i_sel && !o_ready) begin
            if (cnt_r == i_delay) begin
                o_ready <= 1'b1;
                cnt_r <= 3'h0;
                if (i_write) mem_r[unit] <= i_wdata;
            end else cnt_r <= cnt_r + 3'h1;
        end
    end
endmodule // pbg_pbus_model

// file: sim/pbg_gateway_tb.sv
// Self-checking bench for the peripheral bus gateway.
`timescale 1ns/10ps
module pbg_gateway_tb;
    import pbg_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_rst = 1'b1;
    logic i_sys_valid = 1'b0;
    pbg_sys_req_type i_sys_req = '0;
    logic o_sys_ready, o_sys_ack, o_sys_err, o_pbus_write, i_pbus_ready;
    logic [31:0] o_sys_rdata, o_pbus_wdata, i_pbus_rdata, o_irq_pend;
    logic [8:0] o_pbus_sel;
    logic [15:0] o_pbus_addr;
    logic [7:0] i_eng_dma_req = '0, o_dma_req, i_eng_irq = '0;
    logic [3:0] i_dma_unit = '0;
    pbg_dma_attr_type o_dma_attr;
    logic i_lcd_irq = 1'b0;
    logic [5:0] i_unit_en = '0;
    logic [23:0] i_per_pin_out = '0, i_per_pin_oe = '0, i_pin_in = '0;
    logic [23:0] o_per_pin_in, o_pin_out, o_pin_oe, own, dir, lvl;
    logic [2:0] dly = 3'h0;
    logic [31:0] seed = 32'd31498, a, d, rd;
    logic er;
    int err_count = 0;
    int total_checks = 0;
    logic [33:0] bad_tab [5] = '{34'h0_8001_0000, 34'h1_8007_0000,
        34'h2_8002_0002, 34'h2_8008_0000, 34'h2_9005_0000};
    always #12.5 i_core_clk = ~i_core_clk;
    pbg_gateway i_pbg_gateway (.i_core_clk, .i_rst, .i_sys_valid, .i_sys_req, .o_sys_ready,
        .o_sys_ack, .o_sys_err, .o_sys_rdata, .o_pbus_sel, .o_pbus_write, .o_pbus_addr,
        .o_pbus_wdata, .i_pbus_rdata, .i_pbus_ready, .i_eng_dma_req, .o_dma_req, .i_dma_unit,
        .o_dma_attr, .i_eng_irq, .i_lcd_irq, .o_irq_pend, .i_unit_en, .i_per_pin_out,
        .i_per_pin_oe, .o_per_pin_in, .i_pin_in, .o_pin_out, .o_pin_oe);
    pbg_pbus_model i_pbg_pbus_model (.i_core_clk, .i_sel(o_pbus_sel), .i_write(o_pbus_write),
        .i_wdata(o_pbus_wdata), .i_delay(dly), .o_ready(i_pbus_ready), .o_rdata(i_pbus_rdata));
    function logic [31:0] rnd();
        seed = {seed[30:0], ^(seed & 32'h8020_0003)};
        return seed;
    endfunction
    function automatic logic [31:0] wmask(input int u);
        return u == 8 ? 32'hffff_ffff : u > 5 ? 32'h0000_ffff : 32'h0000_00ff;
    endfunction
    function automatic logic [7:0] attr_exp(input int u);
        case (u)
            0, 4: return 8'h41;
            1, 3, 5: return 8'h21;
            6, 7: return 8'h42;
            8: return 8'h84;
            default: return 8'h01;
        endcase
    endfunction
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic xfer(input logic wr, input logic [1:0] sz, input logic [31:0] ad,
        input logic [31:0] wd);
        int n = 0;
        @(posedge i_core_clk);
        i_sys_valid <= 1'b1;
        i_sys_req <= '{wr, sz, ad, wd};
        do @(negedge i_core_clk); while (!o_sys_ready);
        @(posedge i_core_clk);
        i_sys_valid <= 1'b0;
        do @(negedge i_core_clk); while (o_sys_ack !== 1'b1 && ++n < 40);
        chk("sys_ack", 32'h1, {31'h0, o_sys_ack});
        rd = o_sys_rdata;
        er = o_sys_err;
    endtask
    task automatic close_out();
        if (err_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        repeat (5000) @(posedge i_core_clk);
        err_count++;
        close_out();
    end
    initial begin
        repeat (8) @(posedge i_core_clk);
        i_rst <= 1'b0;
        for (int u = 0; u < 9; u++) begin
            a = {u == 8 ? PBG_LCD_BASE : 16'h8000 + 16'(u), 16'(rnd()) & 16'hfffc};
            d = rnd();
            dly <= 3'(rnd());
            xfer(1'b1, PBG_SIZE_WORD, a, d);
            chk("wr_err", 32'h0, {31'h0, er});
            xfer(1'b0, PBG_SIZE_WORD, a, 32'h0);
            chk("rd_data", d & wmask(u), rd);
        end
        foreach (bad_tab[k]) for (int w = 0; w < 2; w++) begin
            xfer(1'(w), bad_tab[k][33:32], bad_tab[k][31:0], rnd());
            chk("bad_err", 32'h1, {31'h0, er});
            chk("bad_rdata", 32'h0, rd);
        end
        dir = 24'(rnd());
        lvl = 24'(rnd());
        xfer(1'b1, PBG_SIZE_WORD, {PBG_PIN_BASE, PBG_OFS_PIN_DIR}, {8'h0, dir});
        xfer(1'b1, PBG_SIZE_WORD, {PBG_PIN_BASE, PBG_OFS_PIN_LVL}, {8'h0, lvl});
        xfer(1'b1, 2'h1, {PBG_PIN_BASE, PBG_OFS_PIN_DIR}, {8'h0, ~dir});
        xfer(1'b0, PBG_SIZE_WORD, {PBG_PIN_BASE, PBG_OFS_PIN_DIR}, 32'h0);
        chk("dir_rd", {8'h0, dir}, rd);
        xfer(1'b0, PBG_SIZE_WORD, {PBG_PIN_BASE, 16'h0008}, 32'h0);
        chk("pin_other", 32'h0, rd);
        for (int g = 0; g < 7; g++) begin
            @(posedge i_core_clk);
            i_unit_en <= g == 0 ? 6'h00 : g == 6 ? 6'h3f : 6'(rnd());
            i_per_pin_out <= 24'(rnd());
            i_per_pin_oe <= 24'(rnd());
            i_pin_in <= 24'(rnd());
            repeat (6) @(posedge i_core_clk);
            @(negedge i_core_clk);
            own = {{4{i_unit_en[5]}}, {2{i_unit_en[4]}}, {2{i_unit_en[3]}},
                {2{i_unit_en[2]}}, 2'b11, {12{i_unit_en[0]}}};
            a = {8'h0, (i_per_pin_oe & own) | (dir & ~own)};
            chk("pin_oe", a, {8'h0, o_pin_oe});
            chk("pin_out", {8'h0, (i_per_pin_out & own) | (lvl & ~own)} & a,
                {8'h0, o_pin_out} & a);
            chk("per_in", {8'h0, i_pin_in}, {8'h0, o_per_pin_in});
            xfer(1'b0, PBG_SIZE_WORD, {PBG_PIN_BASE, PBG_OFS_PIN_LVL}, 32'h0);
            chk("lvl_rd", {8'h0, i_pin_in}, rd);
        end
        for (int k = 0; k < 24; k++) begin
            @(posedge i_core_clk);
            i_dma_unit <= 4'(k % 10);
            i_eng_dma_req <= 8'(rnd());
            i_eng_irq <= k == 0 ? 8'h04 : 8'(rnd());
            i_lcd_irq <= k == 0 ? 1'b0 : 1'(rnd());
            @(posedge i_core_clk);
            @(negedge i_core_clk);
            chk("dma_attr", {24'h0, attr_exp(k % 10)}, {24'h0, o_dma_attr});
            chk("dma_req", {24'h0, i_eng_dma_req}, {24'h0, o_dma_req});
            d = {12'h0, i_eng_irq[7:5], i_eng_irq[4] | i_eng_irq[3], i_eng_irq[1], 1'b0,
                i_eng_irq[0], i_lcd_irq, 12'h0};
            chk("irq_pend", d, o_irq_pend);
        end
        close_out();
    end
endmodule // pbg_gateway_tb
bind pbg_gateway pbg_gateway_sva #(.NUM_PINS(NUM_PINS)) i_pbg_gateway_sva (.i_core_clk,
    .i_rst, .i_sys_valid, .i_sys_req, .o_sys_ready, .o_sys_ack, .o_sys_err, .o_sys_rdata,
    .o_pbus_sel, .o_pbus_write, .o_pbus_addr, .o_pbus_wdata, .i_pbus_ready, .i_dma_unit,
    .o_dma_attr, .i_eng_irq, .i_lcd_irq, .o_irq_pend, .i_per_pin_oe, .o_pin_oe);
